// ---- src/qbpb_map.vh ----
// register offsets, field positions and reset values of the quad port block
`ifndef QBPB_MAP_VH
`define QBPB_MAP_VH

`define QBPB_ADDR_W            8

`define QBPB_OFF_PORT_A_LATCH  8'hc0
`define QBPB_OFF_PORT_B_LATCH  8'hc1
`define QBPB_OFF_PORT_C_LATCH  8'hc2
`define QBPB_OFF_PORT_D_LATCH  8'hc3
`define QBPB_OFF_PORT_A_DIR    8'hc8
`define QBPB_OFF_PORT_B_DIR    8'hc9
`define QBPB_OFF_PORT_C_DIR    8'hca
`define QBPB_OFF_PORT_D_DIR    8'hcb
`define QBPB_OFF_PORT_B_PU     8'hd1
`define QBPB_OFF_PORT_C_PU     8'hd2
`define QBPB_OFF_PORT_B_OD     8'hd5
`define QBPB_OFF_PIN_FUNC      8'hd9
`define QBPB_OFF_KEYSCAN_MODE  8'hf0

`define QBPB_RST_LATCH         8'h00
`define QBPB_RST_DIR           8'h00
`define QBPB_RST_PU            8'h00
`define QBPB_RST_OD            8'h00
`define QBPB_RST_PIN_FUNC      8'h00
`define QBPB_RST_KEYSCAN_MODE  8'h00
`define QBPB_RST_RDATA         8'h00

// pin function select bit positions
`define QBPB_PF_IRQ_A          0
`define QBPB_PF_IRQ_B          1
`define QBPB_PF_IRQ_C          2
`define QBPB_PF_TIMER_EVT      3
`define QBPB_PF_BUZZER         4
`define QBPB_PF_PWM            5

// pin positions of the alternate functions
`define QBPB_PA_BIT_BUZZER     4
`define QBPB_PD_BIT_PWM        1

// lcd duty select codes
`define QBPB_DUTY_STATIC       2'h0
`define QBPB_DUTY_HALF         2'h1
`define QBPB_DUTY_THIRD        2'h2
`define QBPB_DUTY_QUARTER      2'h3

`endif

// ---- src/qbpb_reg.v ----
// plain byte-write register with synchronous reset
`timescale 1ns/1ps
module qbpb_reg #(
  parameter       W   = 8,
  parameter [7:0] RST = 8'h00
) (
  input  wire         clk_sys,
  input  wire         reset,
  input  wire         wr_en,
  input  wire [7:0]   wdata,
  output reg  [W-1:0] q_r
);
  always @(posedge clk_sys) begin
    if (reset) begin
      q_r <= RST[W-1:0];
    end else if (wr_en) begin
      q_r <= wdata[W-1:0];
    end
  end
endmodule // qbpb_reg

// ---- src/qbpb_port.v ----
// one bidirectional port: latch, direction, pull-up, open-drain and pin drive
`timescale 1ns/1ps
`include "qbpb_map.vh"
module qbpb_port #(
  parameter W      = 8,
  parameter HAS_PU = 1,
  parameter HAS_OD = 1
) (
  input  wire         clk_sys,
  input  wire         reset,
  input  wire [7:0]   wdata,
  input  wire         wr_latch,
  input  wire         wr_dir,
  input  wire         wr_pu,
  input  wire         wr_od,
  input  wire         dir_ovr_en,
  input  wire [W-1:0] dir_ovr,
  input  wire [W-1:0] alt_sel,
  input  wire [W-1:0] alt_oe,
  input  wire [W-1:0] alt_out,
  output reg  [W-1:0] pin_out,
  output reg  [W-1:0] pin_oe,
  output reg  [W-1:0] pullup_en,
  output reg  [W-1:0] latch_r,
  output reg  [W-1:0] dir_r,
  output reg  [W-1:0] pu_r,
  output reg  [W-1:0] od_r
);
  reg [W-1:0] dir_eff;
  reg [W-1:0] oe_nxt;
  reg [W-1:0] out_nxt;

  // byte-wide reset values cut to the port width on purpose
  localparam [7:0] RST_LATCH = `QBPB_RST_LATCH;
  localparam [7:0] RST_DIR   = `QBPB_RST_DIR;
  localparam [7:0] RST_PU    = `QBPB_RST_PU;
  localparam [7:0] RST_OD    = `QBPB_RST_OD;

  always @(posedge clk_sys) begin
    if (reset) begin
      latch_r <= RST_LATCH[W-1:0];
      dir_r   <= RST_DIR[W-1:0];
      pu_r    <= RST_PU[W-1:0];
      od_r    <= RST_OD[W-1:0];
    end else begin
      if (wr_latch)
        latch_r <= wdata[W-1:0];
      if (wr_dir)
        dir_r <= wdata[W-1:0];
      if (wr_pu && HAS_PU != 0)
        pu_r <= wdata[W-1:0];
      if (wr_od && HAS_OD != 0)
        od_r <= wdata[W-1:0];
    end
  end

  always @* begin
    dir_eff = dir_ovr_en ? dir_ovr : dir_r;
    // open-drain: a one releases the pin instead of driving it high
    oe_nxt  = dir_eff & ~(od_r & latch_r);
    out_nxt = latch_r & ~od_r;
    oe_nxt  = (oe_nxt & ~alt_sel) | (alt_oe & alt_sel);
    out_nxt = (out_nxt & ~alt_sel) | (alt_out & alt_sel);
  end

  always @(posedge clk_sys) begin
    if (reset) begin
      pin_out   <= {W{1'b0}};
      pin_oe    <= {W{1'b0}};
      pullup_en <= {W{1'b0}};
    end else begin
      pin_out   <= out_nxt;
      pin_oe    <= oe_nxt;
      pullup_en <= pu_r & ~oe_nxt;
    end
  end
endmodule // qbpb_port

// ---- src/qbpb_top.v ----
// quad bidirectional port block: register decode, alternate functions, lcd pin enables
`timescale 1ns/1ps
`include "qbpb_map.vh"
module qbpb_top #(
  parameter PA_W = 8,
  parameter PB_W = 8,
  parameter PC_W = 4,
  parameter PD_W = 4
) (
  input  wire                    clk_sys,
  input  wire                    reset,
  input  wire [`QBPB_ADDR_W-1:0] cpu_addr,
  input  wire [7:0]              cpu_wdata,
  input  wire                    cpu_wr,
  input  wire                    cpu_rd_reg,
  input  wire                    cpu_rd_pin,
  output reg  [7:0]              cpu_rdata,
  input  wire [PA_W-1:0]         port_a_in,
  output wire [PA_W-1:0]         port_a_out,
  output wire [PA_W-1:0]         port_a_oe,
  output wire [PA_W-1:0]         port_a_pullup_en,
  input  wire [PB_W-1:0]         port_b_in,
  output wire [PB_W-1:0]         port_b_out,
  output wire [PB_W-1:0]         port_b_oe,
  output wire [PB_W-1:0]         port_b_pullup_en,
  input  wire [PC_W-1:0]         port_c_in,
  output wire [PC_W-1:0]         port_c_out,
  output wire [PC_W-1:0]         port_c_oe,
  output wire [PC_W-1:0]         port_c_pullup_en,
  input  wire [PD_W-1:0]         port_d_in,
  output wire [PD_W-1:0]         port_d_out,
  output wire [PD_W-1:0]         port_d_oe,
  output wire [PD_W-1:0]         port_d_pullup_en,
  input  wire                    keyscan_active,
  input  wire                    buzzer_src,
  input  wire                    pwm_src,
  output reg                     ext_irq_line_a,
  output reg                     ext_irq_line_b,
  output reg                     ext_irq_line_c,
  output reg                     timer_event_in,
  input  wire [1:0]              lcd_duty_select,
  output reg  [2:0]              lcd_segment_out_en,
  output reg  [2:0]              lcd_common_out_en
);

  // register file decode
  wire wr_pa_latch;
  wire wr_pb_latch;
  wire wr_pc_latch;
  wire wr_pd_latch;
  wire wr_pa_dir;
  wire wr_pb_dir;
  wire wr_pc_dir;
  wire wr_pd_dir;
  wire wr_pb_pu;
  wire wr_pc_pu;
  wire wr_pb_od;
  wire wr_pin_func;
  wire wr_keyscan;

  assign wr_pa_latch = cpu_wr && (cpu_addr == `QBPB_OFF_PORT_A_LATCH);
  assign wr_pb_latch = cpu_wr && (cpu_addr == `QBPB_OFF_PORT_B_LATCH);
  assign wr_pc_latch = cpu_wr && (cpu_addr == `QBPB_OFF_PORT_C_LATCH);
  assign wr_pd_latch = cpu_wr && (cpu_addr == `QBPB_OFF_PORT_D_LATCH);
  assign wr_pa_dir   = cpu_wr && (cpu_addr == `QBPB_OFF_PORT_A_DIR);
  assign wr_pb_dir   = cpu_wr && (cpu_addr == `QBPB_OFF_PORT_B_DIR);
  assign wr_pc_dir   = cpu_wr && (cpu_addr == `QBPB_OFF_PORT_C_DIR);
  assign wr_pd_dir   = cpu_wr && (cpu_addr == `QBPB_OFF_PORT_D_DIR);
  assign wr_pb_pu    = cpu_wr && (cpu_addr == `QBPB_OFF_PORT_B_PU);
  assign wr_pc_pu    = cpu_wr && (cpu_addr == `QBPB_OFF_PORT_C_PU);
  assign wr_pb_od    = cpu_wr && (cpu_addr == `QBPB_OFF_PORT_B_OD);
  assign wr_pin_func = cpu_wr && (cpu_addr == `QBPB_OFF_PIN_FUNC);
  assign wr_keyscan  = cpu_wr && (cpu_addr == `QBPB_OFF_KEYSCAN_MODE);

  wire [7:0] pin_func_r;
  wire [7:0] keyscan_mode_r;

  qbpb_reg #(
    .W   (8),
    .RST (`QBPB_RST_PIN_FUNC)
  ) u_pin_func (
    .clk_sys (clk_sys),
    .reset   (reset),
    .wr_en   (wr_pin_func),
    .wdata   (cpu_wdata),
    .q_r     (pin_func_r)
  );

  qbpb_reg #(
    .W   (8),
    .RST (`QBPB_RST_KEYSCAN_MODE)
  ) u_keyscan_mode (
    .clk_sys (clk_sys),
    .reset   (reset),
    .wr_en   (wr_keyscan),
    .wdata   (cpu_wdata),
    .q_r     (keyscan_mode_r)
  );

  // alternate function routing
  reg [PA_W-1:0] pa_alt_sel;
  reg [PA_W-1:0] pa_alt_oe;
  reg [PA_W-1:0] pa_alt_out;
  reg [PD_W-1:0] pd_alt_sel;
  reg [PD_W-1:0] pd_alt_oe;
  reg [PD_W-1:0] pd_alt_out;

  always @* begin
    pa_alt_sel = {PA_W{1'b0}};
    pa_alt_oe  = {PA_W{1'b0}};
    pa_alt_out = {PA_W{1'b0}};
    pd_alt_sel = {PD_W{1'b0}};
    pd_alt_oe  = {PD_W{1'b0}};
    pd_alt_out = {PD_W{1'b0}};
    // input functions take the pin as a plain input: driver off
    pa_alt_sel[0] = pin_func_r[`QBPB_PF_IRQ_A];
    pa_alt_sel[1] = pin_func_r[`QBPB_PF_IRQ_B];
    pa_alt_sel[2] = pin_func_r[`QBPB_PF_IRQ_C];
    pa_alt_sel[3] = pin_func_r[`QBPB_PF_TIMER_EVT];
    pa_alt_sel[`QBPB_PA_BIT_BUZZER] = pin_func_r[`QBPB_PF_BUZZER];
    pa_alt_oe[`QBPB_PA_BIT_BUZZER]  = 1'b1;
    pa_alt_out[`QBPB_PA_BIT_BUZZER] = buzzer_src;
    pd_alt_sel[`QBPB_PD_BIT_PWM]    = pin_func_r[`QBPB_PF_PWM];
    pd_alt_oe[`QBPB_PD_BIT_PWM]     = 1'b1;
    pd_alt_out[`QBPB_PD_BIT_PWM]    = pwm_src;
  end

  // alternate inputs read zero while their pin stays normal i/o
  always @(posedge clk_sys) begin
    if (reset) begin
      ext_irq_line_a <= 1'b0;
      ext_irq_line_b <= 1'b0;
      ext_irq_line_c <= 1'b0;
      timer_event_in <= 1'b0;
    end else begin
      ext_irq_line_a <= pin_func_r[`QBPB_PF_IRQ_A] & port_a_in[0];
      ext_irq_line_b <= pin_func_r[`QBPB_PF_IRQ_B] & port_a_in[1];
      ext_irq_line_c <= pin_func_r[`QBPB_PF_IRQ_C] & port_a_in[2];
      timer_event_in <= pin_func_r[`QBPB_PF_TIMER_EVT] & port_a_in[3];
    end
  end

  // ports
  wire [PA_W-1:0] pa_latch;
  wire [PA_W-1:0] pa_dir;
  wire [PB_W-1:0] pb_latch;
  wire [PB_W-1:0] pb_dir;
  wire [PB_W-1:0] pb_pu;
  wire [PB_W-1:0] pb_od;
  wire [PC_W-1:0] pc_latch;
  wire [PC_W-1:0] pc_dir;
  wire [PC_W-1:0] pc_pu;
  wire [PD_W-1:0] pd_latch;
  wire [PD_W-1:0] pd_dir;

  qbpb_port #(
    .W      (PA_W),
    .HAS_PU (0),
    .HAS_OD (0)
  ) u_port_a (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .wdata      (cpu_wdata),
    .wr_latch   (wr_pa_latch),
    .wr_dir     (wr_pa_dir),
    .wr_pu      (1'b0),
    .wr_od      (1'b0),
    .dir_ovr_en (1'b0),
    .dir_ovr    ({PA_W{1'b0}}),
    .alt_sel    (pa_alt_sel),
    .alt_oe     (pa_alt_oe),
    .alt_out    (pa_alt_out),
    .pin_out    (port_a_out),
    .pin_oe     (port_a_oe),
    .pullup_en  (port_a_pullup_en),
    .latch_r    (pa_latch),
    .dir_r      (pa_dir),
    .pu_r       (),
    .od_r       ()
  );

  qbpb_port #(
    .W      (PB_W),
    .HAS_PU (1),
    .HAS_OD (1)
  ) u_port_b (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .wdata      (cpu_wdata),
    .wr_latch   (wr_pb_latch),
    .wr_dir     (wr_pb_dir),
    .wr_pu      (wr_pb_pu),
    .wr_od      (wr_pb_od),
    .dir_ovr_en (keyscan_active),
    .dir_ovr    (keyscan_mode_r[PB_W-1:0]),
    .alt_sel    ({PB_W{1'b0}}),
    .alt_oe     ({PB_W{1'b0}}),
    .alt_out    ({PB_W{1'b0}}),
    .pin_out    (port_b_out),
    .pin_oe     (port_b_oe),
    .pullup_en  (port_b_pullup_en),
    .latch_r    (pb_latch),
    .dir_r      (pb_dir),
    .pu_r       (pb_pu),
    .od_r       (pb_od)
  );

  qbpb_port #(
    .W      (PC_W),
    .HAS_PU (1),
    .HAS_OD (0)
  ) u_port_c (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .wdata      (cpu_wdata),
    .wr_latch   (wr_pc_latch),
    .wr_dir     (wr_pc_dir),
    .wr_pu      (wr_pc_pu),
    .wr_od      (1'b0),
    .dir_ovr_en (1'b0),
    .dir_ovr    ({PC_W{1'b0}}),
    .alt_sel    ({PC_W{1'b0}}),
    .alt_oe     ({PC_W{1'b0}}),
    .alt_out    ({PC_W{1'b0}}),
    .pin_out    (port_c_out),
    .pin_oe     (port_c_oe),
    .pullup_en  (port_c_pullup_en),
    .latch_r    (pc_latch),
    .dir_r      (pc_dir),
    .pu_r       (pc_pu),
    .od_r       ()
  );

  qbpb_port #(
    .W      (PD_W),
    .HAS_PU (0),
    .HAS_OD (0)
  ) u_port_d (
    .clk_sys    (clk_sys),
    .reset      (reset),
    .wdata      (cpu_wdata),
    .wr_latch   (wr_pd_latch),
    .wr_dir     (wr_pd_dir),
    .wr_pu      (1'b0),
    .wr_od      (1'b0),
    .dir_ovr_en (1'b0),
    .dir_ovr    ({PD_W{1'b0}}),
    .alt_sel    (pd_alt_sel),
    .alt_oe     (pd_alt_oe),
    .alt_out    (pd_alt_out),
    .pin_out    (port_d_out),
    .pin_oe     (port_d_oe),
    .pullup_en  (port_d_pullup_en),
    .latch_r    (pd_latch),
    .dir_r      (pd_dir),
    .pu_r       (),
    .od_r       ()
  );

  // read path: data comes out one cycle after the read strobe
  reg [7:0] rdata_nxt;

  always @* begin
    rdata_nxt = 8'h00;
    case (cpu_addr)
      `QBPB_OFF_PORT_A_LATCH: rdata_nxt = cpu_rd_pin ? port_a_in : pa_latch;
      `QBPB_OFF_PORT_B_LATCH: rdata_nxt = cpu_rd_pin ? port_b_in : pb_latch;
      `QBPB_OFF_PORT_C_LATCH: rdata_nxt = {4'h0, cpu_rd_pin ? port_c_in : pc_latch};
      `QBPB_OFF_PORT_D_LATCH: rdata_nxt = {4'h0, cpu_rd_pin ? port_d_in : pd_latch};
      `QBPB_OFF_PORT_A_DIR:   rdata_nxt = pa_dir;
      `QBPB_OFF_PORT_B_DIR:   rdata_nxt = pb_dir;
      `QBPB_OFF_PORT_C_DIR:   rdata_nxt = {4'h0, pc_dir};
      `QBPB_OFF_PORT_D_DIR:   rdata_nxt = {4'h0, pd_dir};
      `QBPB_OFF_PORT_B_PU:    rdata_nxt = pb_pu;
      `QBPB_OFF_PORT_C_PU:    rdata_nxt = {4'h0, pc_pu};
      `QBPB_OFF_PORT_B_OD:    rdata_nxt = pb_od;
      `QBPB_OFF_PIN_FUNC:     rdata_nxt = pin_func_r;
      `QBPB_OFF_KEYSCAN_MODE: rdata_nxt = keyscan_mode_r;
      default:                rdata_nxt = 8'h00;
    endcase
  end

  // hold last value between reads so a slow cpu can sample late
  always @(posedge clk_sys) begin
    if (reset) begin
      cpu_rdata <= `QBPB_RST_RDATA;
    end else if (cpu_rd_reg || cpu_rd_pin) begin
      cpu_rdata <= rdata_nxt;
    end
  end

  // lcd pin sharing: commons that the duty does not use go back to segments
  always @(posedge clk_sys) begin
    if (reset) begin
      lcd_common_out_en  <= 3'h0;
      lcd_segment_out_en <= 3'h7;
    end else begin
      case (lcd_duty_select)
        `QBPB_DUTY_STATIC: begin
          lcd_common_out_en  <= 3'h0;
          lcd_segment_out_en <= 3'h7;
        end
        `QBPB_DUTY_HALF: begin
          lcd_common_out_en  <= 3'h1;
          lcd_segment_out_en <= 3'h3;
        end
        `QBPB_DUTY_THIRD: begin
          lcd_common_out_en  <= 3'h3;
          lcd_segment_out_en <= 3'h1;
        end
        `QBPB_DUTY_QUARTER: begin
          lcd_common_out_en  <= 3'h7;
          lcd_segment_out_en <= 3'h0;
        end
        default: begin
          lcd_common_out_en  <= 3'h0;
          lcd_segment_out_en <= 3'h7;
        end
      endcase
    end
  end

endmodule // qbpb_top

// ---- verification/qbpb_chk.sv ----
// assertion checker for the quad port block, bound to its top module
`timescale 1ns/1ps
module qbpb_chk (
  input wire       clk_sys,
  input wire       reset,
  input wire [7:0] cpu_addr,
  input wire [7:0] cpu_wdata,
  input wire       cpu_wr,
  input wire       cpu_rd_reg,
  input wire       cpu_rd_pin,
  input wire [7:0] cpu_rdata,
  input wire [7:0] port_a_in,
  input wire [7:0] port_a_pullup_en,
  input wire [7:0] port_b_oe,
  input wire [7:0] port_b_pullup_en,
  input wire [3:0] port_c_in,
  input wire [3:0] port_c_out,
  input wire [3:0] port_c_oe,
  input wire [3:0] port_d_pullup_en,
  input wire       ext_irq_line_a,
  input wire       timer_event_in,
  input wire [1:0] lcd_duty_select,
  input wire [2:0] lcd_segment_out_en,
  input wire [2:0] lcd_common_out_en
);
  default clocking dc @(posedge clk_sys);
  endclocking
  default disable iff (reset);

  property p_wr_dir;
    cpu_wr && cpu_addr == 8'hca ##1 !(cpu_wr && cpu_addr == 8'hca)
      |=> {4'h0, port_c_oe} == ($past(cpu_wdata, 2) & 8'h0f);
  endproperty
  a_wr_dir: assert property (p_wr_dir) else $error("port c enable off");
  property p_wr_lat;
    cpu_wr && cpu_addr == 8'hc2 ##1 !(cpu_wr && cpu_addr == 8'hc2)
      |=> {4'h0, port_c_out} == ($past(cpu_wdata, 2) & 8'h0f);
  endproperty
  a_wr_lat: assert property (p_wr_lat) else $error("port c drive off");
  property p_rd_reg;
    cpu_rd_reg && !cpu_rd_pin && cpu_addr == 8'hc2 |=> cpu_rdata == {4'h0, port_c_out};
  endproperty
  a_rd_reg: assert property (p_rd_reg) else $error("latch read wrong");
  property p_rd_pin;
    cpu_rd_pin && cpu_addr == 8'hc2 |=> cpu_rdata == {4'h0, $past(port_c_in)};
  endproperty
  a_rd_pin: assert property (p_rd_pin) else $error("pin read wrong");
  property p_unmap;
    (cpu_rd_reg || cpu_rd_pin) && cpu_addr == 8'hc4 |=> cpu_rdata == 8'h00;
  endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_pu_b;
    (port_b_pullup_en & port_b_oe) == 8'h00;
  endproperty
  a_pu_b: assert property (p_pu_b) else $error("pull-up on driven pin");
  property p_pu_ad;
    port_a_pullup_en == 8'h00 && port_d_pullup_en == 4'h0;
  endproperty
  a_pu_ad: assert property (p_pu_ad) else $error("pull-up without select");
  property p_irq;
    ext_irq_line_a |-> $past(port_a_in[0]);
  endproperty
  a_irq: assert property (p_irq) else $error("irq without pin level");
  property p_tmr;
    timer_event_in |-> $past(port_a_in[3]);
  endproperty
  a_tmr: assert property (p_tmr) else $error("timer event without pin");
  property p_com;
    !$past(reset) |-> lcd_common_out_en == {$past(lcd_duty_select) == 2'h3,
      $past(lcd_duty_select) >= 2'h2, $past(lcd_duty_select) != 2'h0};
  endproperty
  a_com: assert property (p_com) else $error("common enables wrong");
  property p_seg;
    lcd_segment_out_en == ~{lcd_common_out_en[0], lcd_common_out_en[1], lcd_common_out_en[2]};
  endproperty
  a_seg: assert property (p_seg) else $error("segment enables wrong");
  c_wr_dir: cover property (cpu_wr && cpu_addr == 8'hca);
  c_rd_pin: cover property (cpu_rd_pin && cpu_addr == 8'hc2);
  c_quarter: cover property (lcd_common_out_en == 3'h7);
endmodule // qbpb_chk

bind qbpb_top qbpb_chk qbpb_chk_i (.clk_sys, .reset, .cpu_addr, .cpu_wdata, .cpu_wr,
  .cpu_rd_reg, .cpu_rd_pin, .cpu_rdata, .port_a_in, .port_a_pullup_en, .port_b_oe,
  .port_b_pullup_en, .port_c_in, .port_c_out, .port_c_oe, .port_d_pullup_en,
  .ext_irq_line_a, .timer_event_in, .lcd_duty_select, .lcd_segment_out_en,
  .lcd_common_out_en);

// ---- verification/qbpb_board.sv ----
// board model: keys, pull-ups and the wire level seen by one port
`timescale 1ns/1ps
module qbpb_board #(
  parameter W = 8
) (
  input  wire         clk_sys,
  input  wire [W-1:0] drv_out,
  input  wire [W-1:0] drv_oe,
  input  wire [W-1:0] pull_en,
  input  wire [W-1:0] key_en,
  input  wire [W-1:0] key_val,
  output wire [W-1:0] pin
);
  reg [W-1:0] float_r = {W{1'b0}};

  // a floating pin must not settle to a convenient value
  always @(posedge clk_sys) begin
    float_r <= ~float_r;
  end
  assign pin = (drv_oe & drv_out)
             | (~drv_oe & key_en & key_val)
             | (~drv_oe & ~key_en & pull_en)
             | (~drv_oe & ~key_en & ~pull_en & float_r);
endmodule // qbpb_board

// ---- verification/qbpb_tb.sv ----
// self-checking bench for the quad port block with a register-level model
`timescale 1ns/1ps
module qbpb_tb;
  localparam [103:0] ADRS = {8'hc0, 8'hc1, 8'hc2, 8'hc3, 8'hc8, 8'hc9, 8'hca,
                             8'hcb, 8'hd1, 8'hd2, 8'hd5, 8'hd9, 8'hf0};
  localparam [103:0] MSKS = {8'hff, 8'hff, 8'h0f, 8'h0f, 8'hff, 8'hff, 8'h0f,
                             8'h0f, 8'hff, 8'h0f, 8'hff, 8'hff, 8'hff};
  reg        clk_sys = 1'b0;
  reg        reset = 1'b1;
  reg  [7:0] cpu_addr = 8'h00;
  reg  [7:0] cpu_wdata = 8'h00;
  reg        cpu_wr = 1'b0;
  reg        cpu_rd_reg = 1'b0;
  reg        cpu_rd_pin = 1'b0;
  reg        keyscan_active = 1'b0;
  reg        buzzer_src = 1'b0;
  reg        pwm_src = 1'b0;
  reg  [1:0] lcd_duty_select = 2'h0;
  reg  [7:0] key_a = 8'h00, key_b = 8'h00, ae, ao, be, bo;
  reg  [3:0] key_c = 4'h0, key_d = 4'h0, ce, co, de, dx;
  reg  [7:0] regm [0:255];
  reg  [31:0] r;
  integer    n_mismatch = 0, samples_checked = 0, cyc = 0, seed = 32'h2d45, i, k, n;
  wire [7:0] cpu_rdata, port_a_in, port_a_out, port_a_oe, port_a_pullup_en;
  wire [7:0] port_b_in, port_b_out, port_b_oe, port_b_pullup_en;
  wire [3:0] port_c_in, port_c_out, port_c_oe, port_c_pullup_en;
  wire [3:0] port_d_in, port_d_out, port_d_oe, port_d_pullup_en;
  wire       ext_irq_line_a, ext_irq_line_b, ext_irq_line_c, timer_event_in;
  wire [2:0] lcd_segment_out_en, lcd_common_out_en;
  // keys released where a pull-up is selected, so those pins read the pull-up
  wire [3:0] kc_en = ~regm[8'hd2][3:0];
  wire [7:0] kb_en = ~regm[8'hd1];

  qbpb_top qbpb_top_i (.clk_sys, .reset, .cpu_addr, .cpu_wdata, .cpu_wr, .cpu_rd_reg,
    .cpu_rd_pin, .cpu_rdata, .port_a_in, .port_a_out, .port_a_oe, .port_a_pullup_en,
    .port_b_in, .port_b_out, .port_b_oe, .port_b_pullup_en, .port_c_in, .port_c_out,
    .port_c_oe, .port_c_pullup_en, .port_d_in, .port_d_out, .port_d_oe,
    .port_d_pullup_en, .keyscan_active, .buzzer_src, .pwm_src, .ext_irq_line_a,
    .ext_irq_line_b, .ext_irq_line_c, .timer_event_in, .lcd_duty_select,
    .lcd_segment_out_en, .lcd_common_out_en);
  qbpb_board #(.W(8)) board_a (.clk_sys, .drv_out(port_a_out), .drv_oe(port_a_oe),
    .pull_en(port_a_pullup_en), .key_en(8'hff), .key_val(key_a), .pin(port_a_in));
  qbpb_board #(.W(8)) board_b (.clk_sys, .drv_out(port_b_out), .drv_oe(port_b_oe),
    .pull_en(port_b_pullup_en), .key_en(kb_en), .key_val(key_b), .pin(port_b_in));
  qbpb_board #(.W(4)) board_c (.clk_sys, .drv_out(port_c_out), .drv_oe(port_c_oe),
    .pull_en(port_c_pullup_en), .key_en(kc_en), .key_val(key_c), .pin(port_c_in));
  qbpb_board #(.W(4)) board_d (.clk_sys, .drv_out(port_d_out), .drv_oe(port_d_oe),
    .pull_en(port_d_pullup_en), .key_en(4'hf), .key_val(key_d), .pin(port_d_in));

  always #10 clk_sys = ~clk_sys;

  task summarize;
    begin
      $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
      if (n_mismatch == 0 && samples_checked > 0)
        $display("RESULT: PASS");
      else
        $display("RESULT: FAIL");
      $finish;
    end
  endtask

  always @(posedge clk_sys) begin
    cyc = cyc + 1;
    if (cyc == 10000) begin
      n_mismatch = n_mismatch + 1;
      summarize;
    end
  end

  task chk(input [47:0] nm, input [7:0] s, input [7:0] e);
    begin
      samples_checked = samples_checked + 1;
      if (s !== e) begin
        n_mismatch = n_mismatch + 1;
        $display("MISMATCH %0s expected %h seen %h", nm, e, s);
      end
    end
  endtask

  task wr(input [7:0] a, input [7:0] d);
    begin
      @(negedge clk_sys);
      cpu_wr = 1'b1;
      cpu_addr = a;
      cpu_wdata = d;
      regm[a] = 8'h00;
      for (k = 0; k < 13; k = k + 1)
        if (ADRS[8*k +: 8] == a)
          regm[a] = d & MSKS[8*k +: 8];
      @(negedge clk_sys);
      cpu_wr = 1'b0;
    end
  endtask

  task rd(input pin, input [7:0] a, input [7:0] e);
    begin
      @(negedge clk_sys);
      cpu_rd_pin = pin;
      cpu_rd_reg = !pin;
      cpu_addr = a;
      @(negedge clk_sys);
      cpu_rd_pin = 1'b0;
      cpu_rd_reg = 1'b0;
      chk("rdata", cpu_rdata, e);
    end
  endtask

  // only bits that are driven carry a meaningful drive value
  task pins;
    begin
      ae = regm[8'hc8] & ~{4'h0, regm[8'hd9][3:0]};
      ao = regm[8'hc0];
      if (regm[8'hd9][4]) begin
        ae[4] = 1'b1;
        ao[4] = buzzer_src;
      end
      be = (keyscan_active ? regm[8'hf0] : regm[8'hc9]) & ~(regm[8'hd5] & regm[8'hc1]);
      bo = regm[8'hc1] & ~regm[8'hd5];
      ce = regm[8'hca][3:0];
      co = regm[8'hc2][3:0];
      de = regm[8'hcb][3:0];
      dx = regm[8'hc3][3:0];
      if (regm[8'hd9][5]) begin
        de[1] = 1'b1;
        dx[1] = pwm_src;
      end
      chk("a_oe", port_a_oe, ae);
      chk("a_out", port_a_out & ae, ao & ae);
      chk("b_oe", port_b_oe, be);
      chk("b_out", port_b_out & be, bo & be);
      chk("b_pu", port_b_pullup_en, regm[8'hd1] & ~be);
      chk("c_oe", {4'h0, port_c_oe}, {4'h0, ce});
      chk("c_out", {4'h0, port_c_out & ce}, {4'h0, co & ce});
      chk("c_pu", {4'h0, port_c_pullup_en}, {4'h0, regm[8'hd2][3:0] & ~ce});
      chk("a_pu", port_a_pullup_en, 8'h00);
      chk("d_pu", {4'h0, port_d_pullup_en}, 8'h00);
      chk("d_oe", {4'h0, port_d_oe}, {4'h0, de});
      chk("d_out", {4'h0, port_d_out & de}, {4'h0, dx & de});
      chk("irq", {4'h0, timer_event_in, ext_irq_line_c, ext_irq_line_b, ext_irq_line_a},
          {4'h0, key_a[3:0] & regm[8'hd9][3:0]});
    end
  endtask

  task rst_chk;
    begin
      @(negedge clk_sys);
      reset = 1'b1;
      repeat (2) @(negedge clk_sys);
      reset = 1'b0;
      for (i = 0; i < 256; i = i + 1)
        regm[i] = 8'h00;
      for (i = 0; i < 13; i = i + 1)
        rd(1'b0, ADRS[8*i +: 8], 8'h00);
      pins;
    end
  endtask

  initial begin
    rst_chk;
    for (n = 0; n < 4; n = n + 1) begin
      lcd_duty_select = n[1:0];
      repeat (2) @(negedge clk_sys);
      chk("com_en", {5'h0, lcd_common_out_en}, {5'h0, n == 3, n >= 2, n != 0});
      chk("seg_en", {5'h0, lcd_segment_out_en}, {5'h0, n == 0, n < 2, n != 3});
    end
    for (n = 0; n < 40; n = n + 1) begin
      for (i = 0; i < 13; i = i + 1) begin
        r = $random(seed);
        wr(ADRS[8*i +: 8], r[7:0]);
      end
      r = $random(seed);
      wr(8'hc4, r[7:0]);
      keyscan_active = r[8];
      buzzer_src = r[9];
      pwm_src = r[10];
      key_a = r[23:16];
      key_b = r[31:24];
      key_c = r[14:11];
      key_d = r[7:4];
      repeat (3) @(negedge clk_sys);
      pins;
      for (i = 0; i < 13; i = i + 1)
        rd(1'b0, ADRS[8*i +: 8], regm[ADRS[8*i +: 8]]);
      rd(1'b0, 8'hc4, 8'h00);
      rd(1'b1, 8'hc0, (ae & ao) | (~ae & key_a));
      rd(1'b1, 8'hc1, (be & bo) | (~be & (regm[8'hd1] | key_b)));
      rd(1'b1, 8'hc2, {4'h0, (ce & co) | (~ce & (regm[8'hd2][3:0] | key_c))});
      rd(1'b1, 8'hc3, {4'h0, (de & dx) | (~de & key_d)});
    end
    rst_chk;
    summarize;
  end
endmodule // qbpb_tb
